//--- logic/power_seq_pkg.sv
/*
  Shared constants, types and register map of the handset power sequencer.
  Assumes a single 125 MHz clock and an APB master with 32-bit data.
*/
package power_seq_pkg;

  // Clock rate and the slow tick that stands in for the low-frequency oscillator.
  localparam int CLK_MHZ = 125;
  localparam int LF_TICK_US = 1000;
  localparam int LF_TICK_CYCLES = LF_TICK_US * CLK_MHZ;

  // Reset hold after the logic rail comes good.
  localparam int RESET_HOLD_MS = 250;
  localparam int RESET_HOLD_TICKS = (RESET_HOLD_MS * 1000) / LF_TICK_US;

  // Depth of the pin synchroniser, used to mask our own enable-line echo.
  localparam int SYNC_STAGES = 2;

  // Register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] EVENT_OFFSET = 8'h08;

  // Control fields: per-output software allow bits.
  localparam int CTRL_AUX1_BIT = 0;
  localparam int CTRL_AUX2_BIT = 1;
  localparam int CTRL_PUMP_BIT = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h7;

  // Event fields, sticky and cleared by writing one.
  localparam int EVT_THERMAL_BIT = 0;
  localparam int EVT_LOCKOUT_BIT = 1;
  localparam int EVT_RAIL_FAIL_BIT = 2;
  localparam int EVT_SYS_OFF_BIT = 3;
  localparam logic [3:0] EVENT_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_POWERED,
    ST_LATCHED,
    ST_HOT
  } power_state_e;

  // Pin levels after synchronisation.
  typedef struct packed {
    logic on_button_n;
    logic remote_power_request;
    logic off_n;
    logic enable_line_in;
    logic logic_rail_good;
    logic supply_ok;
    logic temp_trip;
    logic temp_release;
    logic logic_rail_voltage_select;
    logic aux_reg1_voltage_select;
    logic aux_reg2_voltage_select;
    logic aux1_enable_n;
    logic aux2_enable_n;
    logic pump_enable_n;
    logic aux1_enable_driven;
    logic aux2_enable_driven;
    logic pump_enable_driven;
  } pin_in_s;

endpackage

//--- logic/power_sequencer.sv
/*
  On/off latch, processor reset and rail gating of a handset power supply,
  with an APB register window for software.
  Assumes the rail-good, lockout and thermal comparators arrive as digital
  levels from the analog section and that all pins are asynchronous to clk.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.

// Operation
// - Each voltage-select pin low picks 3.3 V, high picks 3 V, per rail.
// - Aux enable low turns regulator on; high grounds its output and stops it.
// - Aux enables are ignored, regulators off, while processor reset is low.
// - Reset low at power-up or rail low; held 250 ms after rail recovers.
// - Logic rail falling below threshold asserts reset and clears the on-latch.
// - While the on button is held, the enable line is driven low.
// - Enable low powers the core only above lockout and below 160 C.
// - Button pressed while enabled drives the on-status output high.
// - System drives off low after on-status; device shuts down to minimum current.
// - Remote-on input behaves exactly like the on button, including on-status.
// - Remote-on is active high.
// - External low on the enable line powers up but never raises on-status.
// - Everything stays inactive until the supply is above lockout.
// - Die above 160 C shuts the device off and clears the on-latch.
// - After thermal shutdown, restart via button only once below 150 C.
// - Pump enable low runs the pump oscillator and driver; high stops both.
// - Pump enable is ignored, pump stopped, while processor reset is low.
// - Both aux enables and the pump enable default high when undriven.
module power_sequencer #(
  parameter int TICK_CYCLES = power_seq_pkg::LF_TICK_CYCLES,
  parameter int HOLD_TICKS = power_seq_pkg::RESET_HOLD_TICKS
) (
  input wire logic clk, // 125 MHz system clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic on_button_n, // Pushbutton, low while pressed.
  input wire logic remote_power_request, // Remote on request, high active.
  input wire logic off_n, // System off control, low turns off.
  input wire logic enable_line_in, // Sensed level of the shared enable line.
  input wire logic logic_rail_good, // Logic rail above reset threshold.
  input wire logic supply_ok, // Supply above lockout threshold.
  input wire logic temp_trip, // Die above the shutdown temperature.
  input wire logic temp_release, // Die below the restart temperature.
  input wire logic logic_rail_voltage_select, // Logic rail select, high is 3 V.
  input wire logic aux_reg1_voltage_select, // Aux rail 1 select, high is 3 V.
  input wire logic aux_reg2_voltage_select, // Aux rail 2 select, high is 3 V.
  input wire logic aux1_enable_n, // Aux rail 1 enable pin level.
  input wire logic aux2_enable_n, // Aux rail 2 enable pin level.
  input wire logic pump_enable_n, // Charge pump enable pin level.
  input wire logic aux1_enable_driven, // Aux1 pin is driven.
  input wire logic aux2_enable_driven, // Aux2 pin is driven.
  input wire logic pump_enable_driven, // Pump pin is driven.
  output logic enable_line_out_q, // Enable line drive value, always low.
  output logic enable_line_oe_q, // Enable line pulled low while high.
  output logic reset_out_q, // Processor reset drive value, always low.
  output logic reset_oe_q, // Processor reset held low while high.
  output logic on_status_q, // On-status output to the processor.
  output logic reference_enable_q, // Reference and support circuits on.
  output logic logic_rail_enable_q, // Logic regulator on.
  output logic logic_rail_sel_3v_q, // Logic regulator set to 3 V.
  output logic aux_rail1_enable_q, // Aux regulator 1 on.
  output logic aux_rail1_ground_q, // Aux rail 1 forced to ground.
  output logic aux_rail1_sel_3v_q, // Aux regulator 1 set to 3 V.
  output logic aux_rail2_enable_q, // Aux regulator 2 on.
  output logic aux_rail2_ground_q, // Aux rail 2 forced to ground.
  output logic aux_rail2_sel_3v_q, // Aux regulator 2 set to 3 V.
  output logic pump_run_q, // Charge pump oscillator and driver on.
  output logic shutdown_q, // Minimum-current shutdown state.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [power_seq_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata_q, // APB read data.
  output logic pready_q, // APB ready.
  output logic pslverr_q // APB error for unmapped addresses.
);

  power_seq_pkg::pin_in_s pins_raw;
  power_seq_pkg::pin_in_s s;
  power_seq_pkg::power_state_e state_q;
  power_seq_pkg::power_state_e state_d;

  logic [power_seq_pkg::SYNC_STAGES:0] drive_hist_q;
  logic [2:0] control_q;
  logic [3:0] event_q;
  logic btn_req;
  logic ext_en;
  logic en_req;
  logic powered_d;
  logic released;
  logic aux1_off_n;
  logic aux2_off_n;
  logic pump_off_n;
  logic aux1_on_d;
  logic aux2_on_d;
  logic pump_on_d;
  logic setup;
  logic access;
  logic [31:0] rd_word;
  logic rd_hit;
  logic armed_q;
  logic [3:0] evt_set;

  assign pins_raw = {
    on_button_n,
    remote_power_request,
    off_n,
    enable_line_in,
    logic_rail_good,
    supply_ok,
    temp_trip,
    temp_release,
    logic_rail_voltage_select,
    aux_reg1_voltage_select,
    aux_reg2_voltage_select,
    aux1_enable_n,
    aux2_enable_n,
    pump_enable_n,
    aux1_enable_driven,
    aux2_enable_driven,
    pump_enable_driven
  };

  sync_2ff #(
    .WIDTH($bits(power_seq_pkg::pin_in_s))
  ) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_q(s)
  );

  // Button and remote requests are the same event with opposite polarity.
  assign btn_req = ~s.on_button_n | s.remote_power_request;

  // Our own pull echoes back through the synchroniser, so it is masked.
  assign ext_en = ~s.enable_line_in & ~(|drive_hist_q);
  assign en_req = btn_req | ext_en;

  // An undriven enable pin reads high through its pullup.
  assign aux1_off_n = ~s.aux1_enable_driven | s.aux1_enable_n;
  assign aux2_off_n = ~s.aux2_enable_driven | s.aux2_enable_n;
  assign pump_off_n = ~s.pump_enable_driven | s.pump_enable_n;

  always_comb begin
    state_d = state_q;
    case (state_q)
      power_seq_pkg::ST_OFF: begin
        if (en_req && s.supply_ok && !s.temp_trip) begin
          state_d = power_seq_pkg::ST_POWERED;
        end
      end
      power_seq_pkg::ST_POWERED: begin
        if (s.temp_trip) begin
          state_d = power_seq_pkg::ST_HOT;
        end else if (!s.supply_ok) begin
          state_d = power_seq_pkg::ST_OFF;
        end else if (released && s.off_n) begin
          state_d = power_seq_pkg::ST_LATCHED;
        end else if (!en_req) begin
          state_d = power_seq_pkg::ST_OFF;
        end
      end
      power_seq_pkg::ST_LATCHED: begin
        if (s.temp_trip) begin
          state_d = power_seq_pkg::ST_HOT;
        end else if (!s.supply_ok) begin
          state_d = power_seq_pkg::ST_OFF;
        end else if (!s.logic_rail_good) begin
          state_d = power_seq_pkg::ST_OFF;
        end else if (!s.off_n) begin
          state_d = power_seq_pkg::ST_OFF;
        end
      end
      power_seq_pkg::ST_HOT: begin
        // Cooling alone does not restart; a fresh request is needed from off.
        if (s.temp_release) begin
          state_d = power_seq_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = power_seq_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= power_seq_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign powered_d = (state_d == power_seq_pkg::ST_POWERED) ||
                     (state_d == power_seq_pkg::ST_LATCHED);

  // The hold restarts the moment the rail sags, even by one cycle.
  reset_hold_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .HOLD_TICKS(HOLD_TICKS)
  ) u_reset_hold (
    .clk(clk),
    .rst_b(rst_b),
    .run(powered_d && s.logic_rail_good),
    .released_q(released)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_q <= 1'b0;
      reset_oe_q <= 1'b1;
    end else begin
      reset_out_q <= 1'b0;
      reset_oe_q <= ~released;
    end
  end

  // Enable line pull follows the button, but only once the supply is usable.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_line_out_q <= 1'b0;
      enable_line_oe_q <= 1'b0;
      drive_hist_q <= '0;
    end else begin
      enable_line_out_q <= 1'b0;
      enable_line_oe_q <= btn_req && s.supply_ok;
      drive_hist_q <= {drive_hist_q[power_seq_pkg::SYNC_STAGES-1:0], enable_line_oe_q};
    end
  end

  // Only a fresh button or remote press after latching raises on-status, so the
  // press that powered the supply up cannot start the off handshake.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_status_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      on_status_q <= (state_q == power_seq_pkg::ST_LATCHED) && btn_req && armed_q;
      armed_q <= (state_q == power_seq_pkg::ST_LATCHED) && (armed_q || !btn_req);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_enable_q <= 1'b0;
      logic_rail_enable_q <= 1'b0;
      shutdown_q <= 1'b1;
    end else begin
      reference_enable_q <= powered_d;
      logic_rail_enable_q <= powered_d;
      shutdown_q <= (state_d == power_seq_pkg::ST_OFF) ||
                    (state_d == power_seq_pkg::ST_HOT);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      logic_rail_sel_3v_q <= 1'b0;
      aux_rail1_sel_3v_q <= 1'b0;
      aux_rail2_sel_3v_q <= 1'b0;
    end else begin
      logic_rail_sel_3v_q <= s.logic_rail_voltage_select;
      aux_rail1_sel_3v_q <= s.aux_reg1_voltage_select;
      aux_rail2_sel_3v_q <= s.aux_reg2_voltage_select;
    end
  end

  // Gated by the next state too, so a shutdown drops them with the core.
  assign aux1_on_d = powered_d && released && !aux1_off_n &&
                     control_q[power_seq_pkg::CTRL_AUX1_BIT];
  assign aux2_on_d = powered_d && released && !aux2_off_n &&
                     control_q[power_seq_pkg::CTRL_AUX2_BIT];
  assign pump_on_d = powered_d && released && !pump_off_n &&
                     control_q[power_seq_pkg::CTRL_PUMP_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_rail1_enable_q <= 1'b0;
      aux_rail1_ground_q <= 1'b1;
      aux_rail2_enable_q <= 1'b0;
      aux_rail2_ground_q <= 1'b1;
      pump_run_q <= 1'b0;
    end else begin
      aux_rail1_enable_q <= aux1_on_d;
      aux_rail1_ground_q <= ~aux1_on_d;
      aux_rail2_enable_q <= aux2_on_d;
      aux_rail2_ground_q <= ~aux2_on_d;
      pump_run_q <= pump_on_d;
    end
  end

  // APB: zero wait states, ready rises in the first access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      power_seq_pkg::STATUS_OFFSET: begin
        rd_word[1:0] = state_q;
        rd_word[2] = released;
        rd_word[3] = on_status_q;
        rd_word[4] = aux_rail1_enable_q;
        rd_word[5] = aux_rail2_enable_q;
        rd_word[6] = pump_run_q;
        rd_word[7] = s.supply_ok;
        rd_word[8] = s.logic_rail_good;
        rd_word[9] = s.temp_trip;
      end
      power_seq_pkg::CONTROL_OFFSET: begin
        rd_word[2:0] = control_q;
      end
      power_seq_pkg::EVENT_OFFSET: begin
        rd_word[3:0] = event_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~rd_hit;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= power_seq_pkg::CONTROL_RESET;
    end else if (access && pwrite && paddr == power_seq_pkg::CONTROL_OFFSET) begin
      control_q <= pwdata[2:0];
    end
  end

  // Sticky events: a new event in the clearing cycle survives the clear.
  assign evt_set = {
    state_q == power_seq_pkg::ST_LATCHED && state_d == power_seq_pkg::ST_OFF &&
      !s.off_n && s.logic_rail_good && s.supply_ok,
    state_q == power_seq_pkg::ST_LATCHED && !s.logic_rail_good,
    state_q != power_seq_pkg::ST_OFF && state_q != power_seq_pkg::ST_HOT && !s.supply_ok,
    state_q != power_seq_pkg::ST_HOT && state_d == power_seq_pkg::ST_HOT};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_q <= power_seq_pkg::EVENT_RESET;
    end else if (access && pwrite && paddr == power_seq_pkg::EVENT_OFFSET) begin
      event_q <= (event_q & ~pwdata[3:0]) | evt_set;
    end else begin
      event_q <= event_q | evt_set;
    end
  end

endmodule

//--- logic/reset_hold_timer.sv
/*
  Reset hold timer: a prescaler models the slow oscillator and a tick counter
  measures the hold time. Assumes run drops whenever the logic rail is not good.
*/
module reset_hold_timer #(
  parameter int TICK_CYCLES = 125000,
  parameter int HOLD_TICKS = 250
) (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic run, // Rail good and sequencer powered.
  output logic released_q // High once the hold time has elapsed.
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int HW = $clog2(HOLD_TICKS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [HW-1:0] HOLD_END = HW'(HOLD_TICKS);

  logic [PW-1:0] pre_q;
  logic [HW-1:0] hold_q;
  logic tick;

  assign tick = (pre_q == PRE_LAST);

  // Any loss of run restarts the whole measurement from zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= '0;
    end else if (!run || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
    end else if (!run) begin
      hold_q <= '0;
    end else if (tick && hold_q != HOLD_END) begin
      hold_q <= hold_q + HW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      released_q <= 1'b0;
    end else begin
      released_q <= run && (hold_q == HOLD_END);
    end
  end

endmodule

//--- logic/sync_2ff.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; multi-bit words are not kept coherent.
*/
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain.
  output logic [WIDTH-1:0] sync_q // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

//--- sim/power_seq_sva.sv
/*
  Checker for the power sequencer outputs, bound to its top module.
  Assumes each pin reaches the outputs through two sync flops and one register.
*/
module power_seq_sva #(
  parameter int TICK_CYCLES = 4,
  parameter int HOLD_TICKS = 5
) (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic on_button_n, // Button pin.
  input wire logic supply_ok, // Above lockout.
  input wire logic temp_trip, // Too hot.
  input wire logic logic_rail_good, // Rail good.
  input wire logic logic_rail_voltage_select, // Rail select pin.
  input wire logic reset_oe_q, // Reset asserted.
  input wire logic enable_line_oe_q, // Enable line pulled low.
  input wire logic on_status_q, // On status.
  input wire logic logic_rail_enable_q, // Logic regulator on.
  input wire logic logic_rail_sel_3v_q, // Logic rail at 3 V.
  input wire logic aux_rail1_enable_q, // Aux 1 on.
  input wire logic aux_rail1_ground_q, // Aux 1 grounded.
  input wire logic aux_rail2_enable_q, // Aux 2 on.
  input wire logic pump_run_q, // Pump on.
  input wire logic shutdown_q // Shutdown state.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = TICK_CYCLES * HOLD_TICKS;
  // Saturates so that a long powered run cannot wrap it.
  int good_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      good_cnt_q <= 0;
    end else if (!(logic_rail_good && logic_rail_enable_q)) begin
      good_cnt_q <= 0;
    end else if (good_cnt_q < HOLD + 16) begin
      good_cnt_q <= good_cnt_q + 1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ground_inverse_a: assert property (aux_rail1_ground_q == !aux_rail1_enable_q)
    else $error("aux rail 1 ground is not the inverse of its enable");
  aux_gated_a: assert property (reset_oe_q [*2] |->
    !aux_rail1_enable_q && !aux_rail2_enable_q) else $error("aux rail on during reset");
  pump_gated_a: assert property (reset_oe_q [*2] |-> !pump_run_q)
    else $error("pump running during reset");
  rail_select_a: assert property (logic_rail_voltage_select [*4] |-> logic_rail_sel_3v_q)
    else $error("logic rail select not followed");
  lockout_off_a: assert property ((!supply_ok) [*4] |-> shutdown_q && !logic_rail_enable_q)
    else $error("active below lockout");
  thermal_off_a: assert property (temp_trip [*4] |-> shutdown_q && !logic_rail_enable_q)
    else $error("active while too hot");
  button_drive_a: assert property ((!on_button_n && supply_ok) [*4] |-> enable_line_oe_q)
    else $error("enable line not driven while button held");
  rail_reset_a: assert property ((!logic_rail_good) [*4] |=> reset_oe_q)
    else $error("reset released with rail low");
  hold_min_a: assert property ($fell(reset_oe_q) |-> good_cnt_q >= HOLD)
    else $error("reset released before hold time");
  hold_max_a: assert property (good_cnt_q == HOLD + 16 |-> !reset_oe_q)
    else $error("reset held too long");
  cover property ($fell(reset_oe_q));
  cover property ($rose(on_status_q));
  cover property ($rose(pump_run_q));
endmodule

bind power_sequencer power_seq_sva #(.TICK_CYCLES(TICK_CYCLES), .HOLD_TICKS(HOLD_TICKS)) chk (.*);

//--- sim/processor_model.sv
/*
  System processor and logic rail model for the power sequencer.
  Assumes the rail comes good DELAY + 1 cycles after its regulator turns on.
*/
module processor_model #(
  parameter int DELAY = 4
) (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic reset_oe_q, // Processor held in reset.
  input wire logic on_status_q, // Off request from the supply.
  input wire logic logic_rail_enable_q, // Logic regulator on.
  input wire logic rail_fault, // Overload on the logic rail.
  output logic off_n, // Off control, low turns off.
  output logic logic_rail_good // Rail above reset threshold.
);
  timeunit 1ns;
  timeprecision 1ps;
  int rail_q;
  int wait_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rail_q <= 0;
      logic_rail_good <= 1'h0;
    end else begin
      rail_q <= logic_rail_enable_q ? rail_q + ((rail_q < DELAY) ? 1 : 0) : 0;
      logic_rail_good <= logic_rail_enable_q && rail_q >= DELAY && !rail_fault;
    end
  end
  // An unpowered processor holds off low; the enable line is never used here.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b || reset_oe_q) begin
      off_n <= 1'h0;
      wait_q <= 0;
    end else if (wait_q < DELAY) begin
      wait_q <= wait_q + 1;
      off_n <= (wait_q == DELAY - 1);
    end else if (on_status_q) begin
      off_n <= 1'h0;
    end
  end
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for the power sequencer with a processor model.
  Assumes short hold counts so that the run takes a few hundred cycles.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, on_button_n, remote_power_request, ext_en, supply_ok;
  logic temp_trip, temp_release, rail_fault, psel, penable, pwrite, pready_q, pslverr_q;
  logic off_n, logic_rail_good, enable_line_oe_q, reset_oe_q, on_status_q, shutdown_q;
  logic logic_rail_enable_q, aux_rail1_enable_q, aux_rail2_enable_q, pump_run_q, err;
  logic [2:0] vsel, aux_drv, sel_q;
  logic [power_seq_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata_q, rd;
  int fail_count, tests_run;
  power_sequencer #(.TICK_CYCLES(4), .HOLD_TICKS(5)) uut (
    .clk(clk), .rst_b(rst_b), .on_button_n(on_button_n),
    .remote_power_request(remote_power_request), .off_n(off_n),
    .enable_line_in(!(enable_line_oe_q || ext_en)), .logic_rail_good(logic_rail_good),
    .supply_ok(supply_ok), .temp_trip(temp_trip), .temp_release(temp_release),
    .logic_rail_voltage_select(vsel[2]), .aux_reg1_voltage_select(vsel[1]),
    .aux_reg2_voltage_select(vsel[0]), .aux1_enable_n(!aux_drv[0]),
    .aux2_enable_n(!aux_drv[1]), .pump_enable_n(!aux_drv[2]),
    .aux1_enable_driven(aux_drv[0]), .aux2_enable_driven(aux_drv[1]),
    .pump_enable_driven(aux_drv[2]), .enable_line_out_q(), .enable_line_oe_q(enable_line_oe_q),
    .reset_out_q(), .reset_oe_q(reset_oe_q), .on_status_q(on_status_q),
    .reference_enable_q(), .logic_rail_enable_q(logic_rail_enable_q),
    .logic_rail_sel_3v_q(sel_q[2]), .aux_rail1_enable_q(aux_rail1_enable_q),
    .aux_rail1_ground_q(), .aux_rail1_sel_3v_q(sel_q[1]), .aux_rail2_ground_q(),
    .aux_rail2_enable_q(aux_rail2_enable_q), .aux_rail2_sel_3v_q(sel_q[0]),
    .pump_run_q(pump_run_q), .shutdown_q(shutdown_q), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q)
  );
  processor_model #(.DELAY(4)) cpu (
    .clk(clk), .rst_b(rst_b), .reset_oe_q(reset_oe_q), .on_status_q(on_status_q),
    .logic_rail_enable_q(logic_rail_enable_q), .rail_fault(rail_fault), .off_n(off_n),
    .logic_rail_good(logic_rail_good)
  );
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    $display("fail_count %0d tests_run %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready_q !== 1'h1 && n < 50);
    rd = prdata_q;
    err = pslverr_q;
    if (n >= 50) fail_count++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Index 0 is reset, 1 is shutdown, 2 is on-status.
  task automatic wait_for(input int which, input logic lvl);
    logic [2:0] v;
    for (int n = 0; n < 300; n++) begin
      v = {on_status_q, shutdown_q, reset_oe_q};
      if (v[which] === lvl) break;
      @(posedge clk);
    end
    check(v[which], lvl);
  endtask
  task automatic power_on(input logic remote);
    @(posedge clk);
    aux_drv <= 3'h7;
    on_button_n <= remote;
    remote_power_request <= remote;
    cyc(5);
    check(enable_line_oe_q, 1'h1);
    check(logic_rail_enable_q, 1'h1);
    check({aux_rail1_enable_q, aux_rail2_enable_q, pump_run_q}, 3'h0);
    wait_for(0, 1'h0);
    cyc(12);
    on_button_n <= 1'h1;
    remote_power_request <= 1'h0;
    cyc(6);
    check({shutdown_q, aux_rail1_enable_q, aux_rail2_enable_q, pump_run_q}, 4'h7);
  endtask
  task automatic power_off(input logic remote);
    @(posedge clk);
    on_button_n <= remote;
    remote_power_request <= remote;
    wait_for(2, 1'h1);
    on_button_n <= 1'h1;
    remote_power_request <= 1'h0;
    wait_for(1, 1'h1);
    check(logic_rail_enable_q, 1'h0);
  endtask
  task automatic s_on_off();
    for (int i = 0; i < 2; i++) begin
      power_on(i[0]);
      power_off(i[0]);
    end
  endtask
  task automatic s_regs();
    power_on(1'h0);
    apb(1'h0, power_seq_pkg::CONTROL_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0007);
    apb(1'h1, power_seq_pkg::CONTROL_OFFSET, 32'h0000_0003);
    cyc(4);
    check({aux_rail1_enable_q, pump_run_q}, 2'h2);
    apb(1'h0, power_seq_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(rd[1:0], 2'h2);
    apb(1'h1, 8'h0C, 32'h0000_0007);
    check({err, rd}, 33'h1_0000_0000);
    apb(1'h1, power_seq_pkg::CONTROL_OFFSET, 32'h0000_0007);
    aux_drv <= 3'h0;
    cyc(5);
    check({aux_rail1_enable_q, aux_rail2_enable_q, pump_run_q}, 3'h0);
    check(sel_q, 3'h5);
    vsel <= 3'h2;
    cyc(5);
    check(sel_q, 3'h2);
    power_off(1'h0);
  endtask
  task automatic s_ext_lockout();
    @(posedge clk);
    ext_en <= 1'h1;
    wait_for(0, 1'h0);
    cyc(12);
    check({on_status_q, shutdown_q}, 2'h0);
    ext_en <= 1'h0;
    supply_ok <= 1'h0;
    wait_for(1, 1'h1);
    on_button_n <= 1'h0;
    cyc(6);
    check(logic_rail_enable_q, 1'h0);
    on_button_n <= 1'h1;
    supply_ok <= 1'h1;
  endtask
  task automatic s_thermal_rail();
    power_on(1'h0);
    temp_trip <= 1'h1;
    temp_release <= 1'h0;
    wait_for(1, 1'h1);
    temp_trip <= 1'h0;
    on_button_n <= 1'h0;
    cyc(8);
    check(logic_rail_enable_q, 1'h0);
    on_button_n <= 1'h1;
    temp_release <= 1'h1;
    cyc(6);
    power_on(1'h0);
    rail_fault <= 1'h1;
    wait_for(1, 1'h1);
    cyc(1);
    check(reset_oe_q, 1'h1);
    rail_fault <= 1'h0;
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    {rst_b, remote_power_request, ext_en, supply_ok, temp_trip, rail_fault} = 6'h00;
    {psel, penable, pwrite, on_button_n, temp_release} = 5'h03;
    {vsel, aux_drv, paddr, pwdata} = 46'h2800_0000_0000;
    cyc(8);
    rst_b <= 1'h1;
    supply_ok <= 1'h1;
    cyc(2);
    s_on_off();
    s_regs();
    s_ext_lockout();
    s_thermal_rail();
    finish_test();
  end
endmodule
